// ---- verilog/mmn_cfg.svh ----
// Contract
// - file-to-file move takes 12-bit source and destination over 000h..FFFh
// - move is two words: first nibble 1100 source, second 1111 destination
// - move treats the accumulator as an ordinary source or destination
// - move never writes program counter low or the three stack-top bytes
// - move: two words, source read first cycle, last-phase write, no dummy read
// - load literal to accumulator (0000 1110) in one cycle, flags kept
// - store accumulator (0110 111a) copies accumulator to file in one cycle
// - 8-bit file operand reaches any byte of the addressed 256-byte bank
// - access bit 0 selects access bank; access bit 1 uses bank selector
// - access bit 0, extended set on, f <= 5Fh: indexed literal offset addressing
// - multiply by literal: unsigned acc times literal, one cycle, acc kept
// - multiply by file (0000 001a): unsigned 16-bit product, operands kept
// - product high byte to high register, low byte to low register
// - multiplies change no flag, zero product is not flagged
// - negate (0110 110a) replaces file with two's complement, sets N OV C DC Z
//
// Purpose: constants of the move/multiply/negate execution block
// Assumes: 12-bit data space, APB register map at byte addresses
// Notes:   definitions only
`ifndef MMN_CFG_SVH
`define MMN_CFG_SVH

// data space
`define DATA_DEPTH      4096
`define ACC_FILE_ADDR   12'hff0
`define PCL_FILE_ADDR   12'hff9
`define STACK_TOP_LOW_FILE_ADDR  12'hffd
`define STACK_TOP_HIGH_FILE_ADDR  12'hffe
`define STACK_TOP_UPPER_FILE_ADDR  12'hfff
`define ACCESS_SPLIT    8'h60
`define IDX_MAX         8'h5f
`define ACCESS_HI_BANK  4'hf

// opcodes
`define OPC_MOVE1       4'hc
`define OPC_MOVE2       4'hf
`define OPC_LDBANK      8'h01
`define OPC_LDACC       8'h0e
`define OPC_MULLIT      8'h0d
`define OPC_MULFILE     7'h01
`define OPC_STORE       7'h37
`define OPC_NEGATE      7'h36

// phase counts within one instruction cycle
`define Q_DECODE        2'd0
`define Q_READ          2'd1
`define Q_PROCESS       2'd2
`define Q_WRITE         2'd3

// register byte offsets
`define REG_CTRL        12'h000
`define REG_INSTR       12'h004
`define REG_STATUS      12'h008
`define REG_FLAGS       12'h00c
`define REG_ACC         12'h010
`define REG_BANK        12'h014
`define REG_PROD        12'h018
`define REG_IDX_BASE    12'h01c
`define REG_MEM_ADDR    12'h020
`define REG_MEM_DATA    12'h024

// status bit positions
`define ST_BUSY         0
`define ST_AWAIT        1
`define ST_BAD_DEST     2
`define ST_BAD_WORD     3

// reset values
`define RST_ACC         8'h00
`define RST_BANK        8'h00
`define RST_FLAGS       5'h00
`define RST_IDX_BASE    12'h000

`endif

// ---- verilog/exec_pkg.sv ----
// Purpose: shared types of the execution block
// Assumes: constants come from mmn_cfg.svh
// Notes:   flags field order is n, ov, z, dc, c from msb down
`include "mmn_cfg.svh"

package exec_pkg;

    typedef enum logic [3:0] {
        op_none,
        op_move1,
        op_move2,
        op_ldbank,
        op_ldacc,
        op_mullit,
        op_mulfile,
        op_store,
        op_negate
    } op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_run,
        st_wait2,
        st_run2
    } state_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

endpackage : exec_pkg

// ---- verilog/data_mem.sv ----
// Purpose: 4096-byte data space with registered read data
// Assumes: one request per clock, write and read on the same port
// Notes:   no reset on the array; contents are undefined until written
`timescale 1ns/1ps
`include "mmn_cfg.svh"

module data_mem (
    // clock
    input  wire logic                clk,
    // request and answer
    input  wire exec_pkg::mem_req_t  req,
    output logic [7:0]               rdata
);
    import exec_pkg::*;

    logic [7:0] cells [0:`DATA_DEPTH-1];
    logic [7:0] rdata_ff;

    always_ff @(posedge clk)
    begin
        if (req.we)
        begin
            cells[req.addr] <= req.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (req.re)
        begin
            rdata_ff <= cells[req.addr];
        end
    end

    assign rdata = rdata_ff;

endmodule : data_mem

// ---- verilog/move_multiply_negate_exec.sv ----
// Purpose: executes move, literal load, store, multiply and negate words
// Assumes: words issued one at a time over APB; four phases per cycle
// Notes:   every APB transfer ends in its second access cycle
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "mmn_cfg.svh"

module move_multiply_negate_exec (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import exec_pkg::*;

    // instruction sequencing
    state_t      state_ff;
    logic [1:0]  q_ff;
    logic [15:0] instr_ff;
    op_t         op_ff;
    logic [11:0] faddr_ff;
    logic [7:0]  opnd_ff;
    // architectural state
    logic [7:0]  acc_ff;
    logic [7:0]  bank_ff;
    logic [15:0] prod_ff;
    flags_t      flags_ff;
    logic        ext_en_ff;
    logic [11:0] idx_base_ff;
    logic [11:0] mem_addr_ff;
    logic        bad_dest_ff;
    logic        bad_word_ff;
    // bus
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        refuse_ff;

    logic        running;
    logic        setup;
    logic        access1;
    logic        done_ok;
    logic        instr_wr;
    logic [7:0]  mem_rdata;
    mem_req_t    core_req;
    mem_req_t    apb_req;
    mem_req_t    mem_req;
    logic [7:0]  nxt_neg;
    flags_t      nxt_neg_flags;
    logic [15:0] nxt_prod;
    logic [7:0]  wr_val;
    logic        file_write;
    logic        to_acc;
    logic        dest_blocked;
    logic [31:0] rd_val;

    function automatic op_t decode(input logic [15:0] w);
        op_t r;
        r = op_none;
        if (w[15:12] == `OPC_MOVE1)
            r = op_move1;
        else if (w[15:12] == `OPC_MOVE2)
            r = op_move2;
        else if (w[15:8] == `OPC_LDBANK)
            r = op_ldbank;
        else if (w[15:8] == `OPC_LDACC)
            r = op_ldacc;
        else if (w[15:8] == `OPC_MULLIT)
            r = op_mullit;
        else if (w[15:9] == `OPC_MULFILE)
            r = op_mulfile;
        else if (w[15:9] == `OPC_STORE)
            r = op_store;
        else if (w[15:9] == `OPC_NEGATE)
            r = op_negate;
        return r;
    endfunction : decode

    function automatic logic [11:0] file_addr(
        input logic [7:0]  f,
        input logic        a,
        input logic [7:0]  bank,
        input logic        ext,
        input logic [11:0] base
    );
        logic [11:0] r;
        if (a)
            r = {bank[3:0], f};
        else if (ext && (f <= `IDX_MAX))
            r = 12'(base + {4'h0, f});
        else if (f < `ACCESS_SPLIT)
            r = {4'h0, f};
        else
            r = {`ACCESS_HI_BANK, f};
        return r;
    endfunction : file_addr

    function automatic logic is_mapped(input logic [11:0] a);
        logic r;
        unique case (a)
            `REG_CTRL, `REG_INSTR, `REG_STATUS, `REG_FLAGS, `REG_ACC,
            `REG_BANK, `REG_PROD, `REG_IDX_BASE, `REG_MEM_ADDR,
            `REG_MEM_DATA: r = 1'b1;
            default:       r = 1'b0;
        endcase
        return r;
    endfunction : is_mapped

    assign running  = (state_ff == st_run) || (state_ff == st_run2);
    assign setup    = psel && !penable;
    assign access1  = psel && penable && !pready_ff;
    assign done_ok  = psel && penable && pready_ff && !pslverr_ff;
    assign instr_wr = done_ok && pwrite && (paddr == `REG_INSTR);

    // sequencing: four phases per cycle, a move waits for its second word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= st_idle;
            q_ff     <= `Q_DECODE;
            instr_ff <= 16'h0000;
        end
        else
        begin
            unique case (state_ff)
                st_idle:
                begin
                    if (instr_wr)
                    begin
                        instr_ff <= pwdata[15:0];
                        state_ff <= st_run;
                        q_ff     <= `Q_DECODE;
                    end
                end
                st_run:
                begin
                    q_ff <= 2'(q_ff + 2'd1);
                    if (q_ff == `Q_WRITE)
                        state_ff <= (op_ff == op_move1) ? st_wait2 : st_idle;
                end
                st_wait2:
                begin
                    if (instr_wr)
                    begin
                        instr_ff <= pwdata[15:0];
                        q_ff     <= `Q_DECODE;
                        if (decode(pwdata[15:0]) == op_move2)
                            state_ff <= st_run2;
                        else
                            state_ff <= st_idle;
                    end
                end
                st_run2:
                begin
                    q_ff <= 2'(q_ff + 2'd1);
                    if (q_ff == `Q_WRITE)
                        state_ff <= st_idle;
                end
            endcase
        end
    end

    // decode phase: opcode and effective file address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_ff    <= op_none;
            faddr_ff <= 12'h000;
        end
        else if (running && (q_ff == `Q_DECODE))
        begin
            if (state_ff == st_run2)
            begin
                op_ff    <= op_move2;
                faddr_ff <= instr_ff[11:0];
            end
            else if (decode(instr_ff) == op_move1)
            begin
                op_ff    <= op_move1;
                faddr_ff <= instr_ff[11:0];
            end
            else
            begin
                op_ff    <= decode(instr_ff);
                faddr_ff <= file_addr(instr_ff[7:0], instr_ff[8], bank_ff,
                                      ext_en_ff, idx_base_ff);
            end
        end
    end

    // read phase: only the first move cycle, multiply by file and negate read memory
    always_comb
    begin
        core_req       = '0;
        core_req.addr  = faddr_ff;
        core_req.wdata = wr_val;
        core_req.re    = (state_ff == st_run) && (q_ff == `Q_READ)
                         && (faddr_ff != `ACC_FILE_ADDR)
                         && ((op_ff == op_move1) || (op_ff == op_mulfile)
                             || (op_ff == op_negate));
        core_req.we    = file_write && !to_acc && !dest_blocked;
    end

    // process phase: capture literal or file operand
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opnd_ff <= 8'h00;
        else if ((state_ff == st_run) && (q_ff == `Q_PROCESS))
        begin
            if ((op_ff == op_ldbank) || (op_ff == op_ldacc)
                || (op_ff == op_mullit))
                opnd_ff <= instr_ff[7:0];
            else if (faddr_ff == `ACC_FILE_ADDR)
                opnd_ff <= acc_ff;
            else
                opnd_ff <= mem_rdata;
        end
    end

    // write phase datapath
    always_comb
    begin
        nxt_neg          = 8'(8'(~opnd_ff) + 8'h01);
        nxt_neg_flags.c  = (opnd_ff == 8'h00);
        nxt_neg_flags.dc = (opnd_ff[3:0] == 4'h0);
        nxt_neg_flags.ov = (opnd_ff == 8'h80);
        nxt_neg_flags.z  = (nxt_neg == 8'h00);
        nxt_neg_flags.n  = nxt_neg[7];
        nxt_prod         = 16'(acc_ff) * 16'(opnd_ff);
        wr_val           = opnd_ff;
        if (op_ff == op_store)
            wr_val = acc_ff;
        else if (op_ff == op_negate)
            wr_val = nxt_neg;
        file_write = running && (q_ff == `Q_WRITE)
                     && ((op_ff == op_store) || (op_ff == op_negate)
                         || ((op_ff == op_move2) && (state_ff == st_run2)));
        to_acc       = (faddr_ff == `ACC_FILE_ADDR);
        dest_blocked = (op_ff == op_move2)
                       && ((faddr_ff == `PCL_FILE_ADDR)
                           || (faddr_ff == `STACK_TOP_LOW_FILE_ADDR)
                           || (faddr_ff == `STACK_TOP_HIGH_FILE_ADDR)
                           || (faddr_ff == `STACK_TOP_UPPER_FILE_ADDR));
    end

    // accumulator: literal load, file writes that land on it, software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_ff <= `RST_ACC;
        else if (running && (q_ff == `Q_WRITE) && (op_ff == op_ldacc))
            acc_ff <= opnd_ff;
        else if (file_write && to_acc)
            acc_ff <= wr_val;
        else if (done_ok && pwrite && (paddr == `REG_ACC))
            acc_ff <= pwdata[7:0];
    end

    // bank selector: upper nibble is held at zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bank_ff <= `RST_BANK;
        else if (running && (q_ff == `Q_WRITE) && (op_ff == op_ldbank))
            bank_ff <= {4'h0, opnd_ff[3:0]};
        else if (done_ok && pwrite && (paddr == `REG_BANK))
            bank_ff <= {4'h0, pwdata[3:0]};
    end

    // product pair; multiplies leave flags and both operands alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prod_ff <= 16'h0000;
        else if (running && (q_ff == `Q_WRITE)
                 && ((op_ff == op_mullit) || (op_ff == op_mulfile)))
            prod_ff <= nxt_prod;
    end

    // flags change only on negate or a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_ff <= `RST_FLAGS;
        else if (running && (q_ff == `Q_WRITE) && (op_ff == op_negate))
            flags_ff <= nxt_neg_flags;
        else if (done_ok && pwrite && (paddr == `REG_FLAGS))
            flags_ff <= pwdata[4:0];
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_en_ff   <= 1'b0;
            idx_base_ff <= `RST_IDX_BASE;
            mem_addr_ff <= 12'h000;
        end
        else if (done_ok && pwrite)
        begin
            if (paddr == `REG_CTRL)
                ext_en_ff <= pwdata[0];
            if (paddr == `REG_IDX_BASE)
                idx_base_ff <= pwdata[11:0];
            if (paddr == `REG_MEM_ADDR)
                mem_addr_ff <= pwdata[11:0];
        end
    end

    // sticky error bits; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bad_dest_ff <= 1'b0;
            bad_word_ff <= 1'b0;
        end
        else
        begin
            if (file_write && dest_blocked)
                bad_dest_ff <= 1'b1;
            else if (done_ok && pwrite && (paddr == `REG_STATUS)
                     && pwdata[`ST_BAD_DEST])
                bad_dest_ff <= 1'b0;
            if ((state_ff == st_wait2) && instr_wr
                && (decode(pwdata[15:0]) != op_move2))
                bad_word_ff <= 1'b1;
            else if (done_ok && pwrite && (paddr == `REG_STATUS)
                     && pwdata[`ST_BAD_WORD])
                bad_word_ff <= 1'b0;
        end
    end

    // memory port: core owns it while running, the window otherwise
    always_comb
    begin
        apb_req       = '0;
        apb_req.addr  = mem_addr_ff;
        apb_req.wdata = pwdata[7:0];
        apb_req.re    = setup && !pwrite && (paddr == `REG_MEM_DATA)
                        && !running;
        apb_req.we    = done_ok && pwrite && (paddr == `REG_MEM_DATA);
        mem_req       = running ? core_req : apb_req;
    end

    data_mem u_mem (
        .clk   (pclk),
        .req   (mem_req),
        .rdata (mem_rdata)
    );

    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `REG_CTRL:     rd_val[0] = ext_en_ff;
            `REG_INSTR:    rd_val[15:0] = instr_ff;
            `REG_STATUS:
            begin
                rd_val[`ST_BUSY]     = running;
                rd_val[`ST_AWAIT]    = (state_ff == st_wait2);
                rd_val[`ST_BAD_DEST] = bad_dest_ff;
                rd_val[`ST_BAD_WORD] = bad_word_ff;
            end
            `REG_FLAGS:    rd_val[4:0] = flags_ff;
            `REG_ACC:      rd_val[7:0] = acc_ff;
            `REG_BANK:     rd_val[7:0] = bank_ff;
            `REG_PROD:     rd_val[15:0] = prod_ff;
            `REG_IDX_BASE: rd_val[11:0] = idx_base_ff;
            `REG_MEM_ADDR: rd_val[11:0] = mem_addr_ff;
            `REG_MEM_DATA: rd_val[7:0] = mem_rdata;
            default:       rd_val = 32'h0000_0000;
        endcase
    end

    // apb: refusal decided at setup so a run ending mid-transfer
    // cannot hand back a stale memory byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            refuse_ff  <= 1'b0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            if (setup)
                refuse_ff <= !is_mapped(paddr)
                             || (running && pwrite
                                 && (paddr != `REG_STATUS))
                             || (running && (paddr == `REG_MEM_DATA));
            if (access1)
            begin
                pready_ff  <= 1'b1;
                pslverr_ff <= refuse_ff;
                prdata_ff  <= (refuse_ff || pwrite) ? 32'h0000_0000
                                                    : rd_val;
            end
            else
            begin
                pready_ff  <= 1'b0;
                pslverr_ff <= 1'b0;
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

endmodule : move_multiply_negate_exec

// ---- test/mmn_asserts.sv ----
// Purpose: port-level checks of the execution block
// Assumes: every apb transfer is a setup cycle plus two access cycles
// Notes:   sees only the top ports; busy is inferred from accepted words
`timescale 1ns/1ps
`include "mmn_cfg.svh"

module mmn_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic done = psel && penable && pready && !pwrite;

    sequence instr_ok;
        psel && penable && pready && pwrite && paddr == `REG_INSTR
            && !pslverr;
    endsequence
    sequence setup_at(logic [11:0] a);
        psel && !penable && paddr == a;
    endsequence

    AST_READY_TWO: assert property (psel && !penable |->
        ##1 !pready ##1 pready) else $error("pready not two after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    AST_INSTR_BUSY: assert property (instr_ok ##2 (setup_at(`REG_INSTR)
        and pwrite) |-> ##2 pslverr) else $error("word taken while busy");
    AST_MEM_BUSY: assert property (instr_ok ##2 setup_at(`REG_MEM_DATA)
        |-> ##2 pslverr) else $error("memory window open while busy");
    AST_BANK_NIBBLE: assert property (done && paddr == `REG_BANK
        |-> prdata[31:4] == 28'h0) else $error("bank upper bits set");
    AST_ACC_BYTE: assert property (done && paddr == `REG_ACC
        |-> prdata[31:8] == 24'h0) else $error("acc wider than a byte");
    AST_PROD_WIDTH: assert property (done && paddr == `REG_PROD
        |-> prdata[31:16] == 16'h0) else $error("product wider than 16");
    AST_FLAGS_WIDTH: assert property (done && paddr == `REG_FLAGS
        |-> prdata[31:5] == 27'h0) else $error("flags wider than five");
endmodule : mmn_asserts

bind move_multiply_negate_exec mmn_asserts mmn_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// ---- test/move_multiply_negate_exec_tb.sv ----
// Purpose: register-level test of the execution block
// Assumes: words issued through the instruction register, polled on busy
// Notes:   memory is read back through the address/data window
`timescale 1ns/1ps
`include "mmn_cfg.svh"

module move_multiply_negate_exec_tb;
    import exec_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  nin [3] = '{8'h3a, 8'h80, 8'h00};
    logic [7:0]  res;
    int          errors = 0;
    int          num_checks = 0;

    always #4 pclk = ~pclk;

    move_multiply_negate_exec move_multiply_negate_exec_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task wrap_up;
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // an idle cycle separates transfers so no signal is driven twice a step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rd_chk

    task wait_idle;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `REG_STATUS, 32'h0);
            n++;
        end
        while (rd[`ST_BUSY] !== 1'b0 && n < 10);
        if (rd[`ST_BUSY] !== 1'b0)
        begin
            errors++;
            wrap_up();
        end
    endtask : wait_idle

    task run(input logic [15:0] w);
        apb(1'b1, `REG_INSTR, {16'h0, w});
        wait_idle();
    endtask : run

    task mem_set(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, `REG_MEM_ADDR, {20'h0, a});
        apb(1'b1, `REG_MEM_DATA, {24'h0, v});
    endtask : mem_set

    task mem_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b1, `REG_MEM_ADDR, {20'h0, a});
        rd_chk(nm, `REG_MEM_DATA, {24'h0, e});
    endtask : mem_chk

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("acc", `REG_ACC, 32'h0);
        rd_chk("bank", `REG_BANK, 32'h0);
        rd_chk("prod", `REG_PROD, 32'h0);
        apb(1'b0, 12'h002, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, `REG_FLAGS, 32'h15);
        run(16'h0ee2);
        rd_chk("ldacc", `REG_ACC, 32'he2);
        run(16'h0dc4);
        rd_chk("mullit", `REG_PROD, 32'had08);
        rd_chk("mul acc", `REG_ACC, 32'he2);
        rd_chk("mul flags", `REG_FLAGS, 32'h15);
        run(16'h01ff);
        rd_chk("ldbank", `REG_BANK, 32'h0f);
        run(16'h0102);
        run(16'h6f34);
        mem_chk("store bank", 12'h234, 8'he2);
        run(16'h6e70);
        mem_chk("access hi", 12'hf70, 8'he2);
        run(16'h6e10);
        mem_chk("access lo", 12'h010, 8'he2);
        apb(1'b1, `REG_CTRL, 32'h1);
        apb(1'b1, `REG_IDX_BASE, 32'h100);
        run(16'h6e20);
        mem_chk("indexed", 12'h120, 8'he2);
        run(16'h6e60);
        mem_chk("index edge", 12'hf60, 8'he2);
        apb(1'b1, `REG_CTRL, 32'h0);
        mem_set(12'h234, 8'hb5);
        run(16'h0ec4);
        run(16'h0334);
        rd_chk("mulfile", `REG_PROD, 32'h8a94);
        mem_chk("mul operand", 12'h234, 8'hb5);
        rd_chk("mulfile flags", `REG_FLAGS, 32'h15);
        foreach (nin[i])
        begin
            res = ~nin[i] + 8'h01;
            mem_set(12'h234, nin[i]);
            run(16'h6d34);
            mem_chk("negate", 12'h234, res);
            rd_chk("neg flags", `REG_FLAGS, {27'h0, res[7], nin[i] == 8'h80,
                res == 8'h00, nin[i][3:0] == 4'h0, nin[i] == 8'h00});
        end
        mem_set(12'h123, 8'h33);
        run(16'hc123);
        rd_chk("await", `REG_STATUS, 32'h2);
        run(16'hf456);
        mem_chk("move", 12'h456, 8'h33);
        mem_set(12'h034, 8'h5a);
        run(16'hf034);
        mem_chk("lone second word", 12'h034, 8'h5a);
        run(16'hc123);
        run(16'hfff0);
        rd_chk("move to acc", `REG_ACC, 32'h33);
        run(16'hc010);
        run(16'hfffc);
        mem_chk("move far", 12'hffc, 8'he2);
        mem_set(12'hff9, 8'h11);
        run(16'hc123);
        run(16'hfff9);
        mem_chk("bad dest", 12'hff9, 8'h11);
        rd_chk("bad dest st", `REG_STATUS, 32'h4);
        apb(1'b1, `REG_STATUS, 32'hc);
        run(16'hc123);
        run(16'h0e11);
        rd_chk("bad word acc", `REG_ACC, 32'h33);
        rd_chk("bad word st", `REG_STATUS, 32'h8);
        apb(1'b1, `REG_INSTR, 32'h0e77);
        apb(1'b1, `REG_INSTR, 32'h0e55);
        chk("busy word", 32'h1, {31'h0, err});
        wait_idle();
        rd_chk("busy acc", `REG_ACC, 32'h77);
        apb(1'b1, `REG_INSTR, 32'h0e66);
        apb(1'b0, `REG_MEM_DATA, 32'h0);
        chk("busy mem", 32'h1, {31'h0, err});
        wait_idle();
        wrap_up();
    end
endmodule : move_multiply_negate_exec_tb
